// ---- logic/prog_link_defines.svh ----
`ifndef PROG_LINK_DEFINES_SVH
`define PROG_LINK_DEFINES_SVH

// ----------------------------------------
// Clock and link timing
// ----------------------------------------
`define CLK_MHZ 200
`define SYNC_MIN_US 1700
`define SYNC_MAX_US 1800
`define OUT_BIT_US 3000
`define ACT_MIN_US 50
`define ACT_MAX_US 200
`define OUT_ONE_PCT 65

// ----------------------------------------
// Telegram layout
// ----------------------------------------
`define HDR_BITS 9
`define WR_BITS 24
`define PAYLOAD_W 14
`define OP_HI 23
`define OP_LO 21
`define OPP_BIT 20
`define SEL_HI 19
`define SEL_LO 16
`define SELP_BIT 15
`define DAT_HI 14
`define DAT_LO 1

// ----------------------------------------
// Opcodes and special select
// ----------------------------------------
`define OP_READ 3'h2
`define OP_WRITE 3'h3
`define OP_BURN 3'h4
`define OP_ERASE 3'h5
`define OP_LOCK 3'h7
`define SEL_DEACT 4'hf
`define DEACT_KEY 14'h080f

// ----------------------------------------
// Register widths by select code
// ----------------------------------------
`define REGW_1 10
`define REGW_2 11
`define REGW_3 11
`define REGW_4 14
`define REGW_5 6
`define REGW_6 1
`define REGW_7 14
`define REGW_8 5
`define REGW_9 5
`define REGW_11 6
`define REGW_12 5
`define REGW_13 8
`define REGW_15 12
`define REGW_OTHER 14

`endif

// ---- logic/prog_link_pkg.sv ----
package prog_link_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_SYNC, RX_BITS} rx_state_e;
  typedef enum logic {TX_IDLE, TX_BIT} tx_state_e;
endpackage

// ---- logic/supply_modulated_prog_link.sv ----
`include "prog_link_defines.svh"

module supply_modulated_prog_link
  import prog_link_pkg::*;
#(
  parameter int CW = 20,
  parameter int SYNC_MIN_CYC = `SYNC_MIN_US * `CLK_MHZ,
  parameter int SYNC_MAX_CYC = `SYNC_MAX_US * `CLK_MHZ,
  parameter int OUT_BIT_CYC = `OUT_BIT_US * `CLK_MHZ,
  parameter int ACT_MIN_CYC = `ACT_MIN_US * `CLK_MHZ,
  parameter int ACT_MAX_CYC = `ACT_MAX_US * `CLK_MHZ
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic supply_level,
  input wire logic prog_level,
  input wire logic out_pin_in,
  output logic out_pin_out,
  output logic out_pin_oe_n,
  output logic [3:0] reg_sel,
  output logic [13:0] reg_wdata,
  output logic reg_write,
  input wire logic [13:0] reg_rdata,
  output logic erase_cmd,
  output logic lock_cmd,
  output logic burn_nv,
  output logic active
);

  if (SYNC_MIN_CYC < 16 || SYNC_MAX_CYC < SYNC_MIN_CYC ||
      OUT_BIT_CYC < 8 || ACT_MAX_CYC < ACT_MIN_CYC ||
      SYNC_MAX_CYC * 2 >= (1 << CW) || OUT_BIT_CYC >= (1 << CW) ||
      ACT_MAX_CYC >= (1 << CW))
  begin : g_bad
    $error("supply_modulated_prog_link: bad timing parameters");
  end

  localparam logic [CW-1:0] SMIN = CW'(SYNC_MIN_CYC);
  localparam logic [CW-1:0] SMAX = CW'(SYNC_MAX_CYC);
  localparam logic [CW-1:0] OBIT = CW'(OUT_BIT_CYC);
  localparam logic [CW-1:0] OMID = CW'(OUT_BIT_CYC * `OUT_ONE_PCT / 100);
  localparam logic [CW-1:0] AMIN = CW'(ACT_MIN_CYC);
  localparam logic [CW-1:0] AMAX = CW'(ACT_MAX_CYC);

  function automatic logic [4:0] reg_width(input logic [3:0] s);
    logic [4:0] w;
    w = 5'(`REGW_OTHER);
    unique case (s)
      4'h1: w = 5'(`REGW_1);
      4'h2: w = 5'(`REGW_2);
      4'h3: w = 5'(`REGW_3);
      4'h4: w = 5'(`REGW_4);
      4'h5: w = 5'(`REGW_5);
      4'h6: w = 5'(`REGW_6);
      4'h7: w = 5'(`REGW_7);
      4'h8: w = 5'(`REGW_8);
      4'h9: w = 5'(`REGW_9);
      4'hb: w = 5'(`REGW_11);
      4'hc: w = 5'(`REGW_12);
      4'hd: w = 5'(`REGW_13);
      4'hf: w = 5'(`REGW_15);
      default: w = 5'(`REGW_OTHER);
    endcase
    return w;
  endfunction

  // ----------------------------------------
  // Receiver on the supply line
  // ----------------------------------------
  rx_state_e rx_ff, nxt_rx;
  logic [CW-1:0] cnt_ff, nxt_cnt, period_ff, nxt_period;
  logic [23:0] shift_ff, nxt_shift, frame_ff, nxt_frame;
  logic [4:0] nbits_ff, nxt_nbits;
  logic mid_ff, nxt_mid, done_ff, nxt_done, prev_ff;
  logic edge_seen;
  logic [23:0] shifted;
  logic [4:0] nb_inc;

  assign edge_seen = supply_level ^ prev_ff;
  assign shifted = {shift_ff[22:0], mid_ff};
  assign nb_inc = nbits_ff + 5'h1;

  always_comb
  begin
    nxt_rx = rx_ff;
    nxt_cnt = cnt_ff + CW'(1);
    nxt_period = period_ff;
    nxt_shift = shift_ff;
    nxt_frame = frame_ff;
    nxt_nbits = nbits_ff;
    nxt_mid = mid_ff;
    nxt_done = 1'b0;
    unique case (rx_ff)
      RX_IDLE:
      begin
        nxt_cnt = '0;
        if (edge_seen)
          nxt_rx = RX_SYNC;
      end
      RX_SYNC:
      begin
        if (edge_seen && cnt_ff >= SMIN && cnt_ff <= SMAX)
        begin
          nxt_period = cnt_ff;
          nxt_rx = RX_BITS;
          nxt_cnt = '0;
          nxt_nbits = '0;
          nxt_mid = 1'b0;
        end
        else if (edge_seen)
          nxt_cnt = '0;
        else if (cnt_ff > SMAX)
          nxt_rx = RX_IDLE;
      end
      RX_BITS:
      begin
        if (edge_seen && cnt_ff < period_ff - (period_ff >> 3))
          nxt_mid = 1'b1;
        else if (edge_seen)
        begin
          nxt_shift = shifted;
          nxt_nbits = nb_inc;
          nxt_mid = 1'b0;
          nxt_cnt = '0;
          if (nb_inc == 5'(`HDR_BITS) && shifted[8:6] != `OP_WRITE)
          begin
            nxt_frame = {shifted[8:0], 15'h0};
            nxt_done = 1'b1;
            nxt_rx = RX_IDLE;
          end
          else if (nb_inc == 5'(`WR_BITS))
          begin
            nxt_frame = shifted;
            nxt_done = 1'b1;
            nxt_rx = RX_IDLE;
          end
        end
        else if (cnt_ff > period_ff + (period_ff >> 1))
          nxt_rx = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rx_ff <= RX_IDLE;
      cnt_ff <= '0;
      period_ff <= '0;
      shift_ff <= '0;
      frame_ff <= '0;
      nbits_ff <= '0;
      mid_ff <= 1'b0;
      done_ff <= 1'b0;
      prev_ff <= 1'b1;
    end
    else
    begin
      rx_ff <= nxt_rx;
      cnt_ff <= nxt_cnt;
      period_ff <= nxt_period;
      shift_ff <= nxt_shift;
      frame_ff <= nxt_frame;
      nbits_ff <= nxt_nbits;
      mid_ff <= nxt_mid;
      done_ff <= nxt_done;
      prev_ff <= supply_level;
    end
  end

  // ----------------------------------------
  // Decode and execute
  // ----------------------------------------
  logic [2:0] op;
  logic [3:0] sel;
  logic [13:0] dat;
  logic par_ok, go;
  logic tx_busy;
  logic active_ff, nxt_active, write_ff, nxt_write;

  assign op = frame_ff[`OP_HI:`OP_LO];
  assign sel = frame_ff[`SEL_HI:`SEL_LO];
  assign dat = frame_ff[`DAT_HI:`DAT_LO];
  assign par_ok = (frame_ff[`OPP_BIT] == ^(~op)) &&
                  (frame_ff[`SELP_BIT] == ^(~sel)) &&
                  (op != `OP_WRITE || frame_ff[0] == ~^(~dat));
  assign go = done_ff && par_ok && active_ff && !tx_busy;

  logic erase_ff, nxt_erase, lock_ff, nxt_lock;
  logic armed_ff, nxt_armed, burn_ff, nxt_burn;
  logic [CW-1:0] act_ff, nxt_act;
  logic start, is_read;

  always_comb
  begin
    nxt_active = active_ff;
    nxt_write = 1'b0;
    nxt_erase = 1'b0;
    nxt_lock = 1'b0;
    nxt_armed = armed_ff && !(burn_ff && !prog_level);
    nxt_burn = armed_ff && prog_level;
    nxt_act = '0;
    start = 1'b0;
    is_read = 1'b0;
    if (go)
    begin
      unique case (op)
        `OP_READ:
        begin
          start = 1'b1;
          is_read = 1'b1;
        end
        `OP_WRITE:
        begin
          nxt_write = 1'b1;
          start = 1'b1;
          if (sel == `SEL_DEACT && dat == `DEACT_KEY)
            nxt_active = 1'b0;
        end
        `OP_BURN:
        begin
          nxt_armed = 1'b1;
          start = 1'b1;
        end
        `OP_ERASE:
        begin
          nxt_erase = 1'b1;
          start = 1'b1;
        end
        `OP_LOCK:
        begin
          nxt_lock = 1'b1;
          start = 1'b1;
        end
        default: start = 1'b0;
      endcase
    end
    if (!active_ff && out_pin_oe_n)
    begin
      if (out_pin_in)
        nxt_act = (act_ff > AMAX) ? act_ff : act_ff + CW'(1);
      else if (act_ff >= AMIN && act_ff <= AMAX)
        nxt_active = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      active_ff <= 1'b1;
      write_ff <= 1'b0;
      erase_ff <= 1'b0;
      lock_ff <= 1'b0;
      armed_ff <= 1'b0;
      burn_ff <= 1'b0;
      act_ff <= '0;
    end
    else
    begin
      active_ff <= nxt_active;
      write_ff <= nxt_write;
      erase_ff <= nxt_erase;
      lock_ff <= nxt_lock;
      armed_ff <= nxt_armed;
      burn_ff <= nxt_burn;
      act_ff <= nxt_act;
    end
  end

  assign reg_sel = frame_ff[`SEL_HI:`SEL_LO];
  assign reg_wdata = frame_ff[`DAT_HI:`DAT_LO];
  assign reg_write = write_ff;
  assign erase_cmd = erase_ff;
  assign lock_cmd = lock_ff;
  assign burn_nv = burn_ff;
  assign active = active_ff;

  // ----------------------------------------
  // Answer on the output pin
  // ----------------------------------------
  tx_state_e tx_ff, nxt_tx;
  logic [15:0] tx_shift_ff, nxt_tx_shift;
  logic [4:0] left_ff, nxt_left;
  logic [CW-1:0] tcnt_ff, nxt_tcnt;
  logic level_ff, nxt_level;
  logic [13:0] lead;

  assign lead = reg_rdata << (5'(`PAYLOAD_W) - reg_width(sel));
  assign tx_busy = (tx_ff != TX_IDLE);

  always_comb
  begin
    nxt_tx = tx_ff;
    nxt_tx_shift = tx_shift_ff;
    nxt_left = left_ff;
    nxt_tcnt = tcnt_ff + CW'(1);
    nxt_level = level_ff;
    unique case (tx_ff)
      TX_IDLE:
      begin
        nxt_tcnt = '0;
        nxt_level = 1'b1;
        if (start)
        begin
          nxt_tx = TX_BIT;
          nxt_tx_shift = {1'b0, lead, ~^(~lead)};
          nxt_left = is_read ? 5'h10 : 5'h1;
        end
      end
      TX_BIT:
      begin
        if (tcnt_ff == OMID && tx_shift_ff[15])
          nxt_level = ~level_ff;
        if (tcnt_ff == OBIT - CW'(1))
        begin
          nxt_level = ~level_ff;
          nxt_tcnt = '0;
          nxt_tx_shift = {tx_shift_ff[14:0], 1'b0};
          nxt_left = left_ff - 5'h1;
          if (left_ff == 5'h1)
            nxt_tx = TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_ff <= TX_IDLE;
      tx_shift_ff <= '0;
      left_ff <= '0;
      tcnt_ff <= '0;
      level_ff <= 1'b1;
    end
    else
    begin
      tx_ff <= nxt_tx;
      tx_shift_ff <= nxt_tx_shift;
      left_ff <= nxt_left;
      tcnt_ff <= nxt_tcnt;
      level_ff <= nxt_level;
    end
  end

  // Final toggle lands in the same cycle as release; the pull-down takes over
  assign out_pin_out = level_ff;
  assign out_pin_oe_n = !tx_busy;

endmodule

// ---- verification/prog_link_monitor.sv ----
module prog_link_monitor #(
  parameter int OUT_BIT_CYC = 600000
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic prog_level,
  input wire logic out_pin_out,
  input wire logic out_pin_oe_n,
  input wire logic reg_write,
  input wire logic erase_cmd,
  input wire logic burn_nv,
  input wire logic active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] gap_ff;
  logic [31:0] nxt_gap;
  logic out_q_ff;
  logic nxt_out_q;
  // ------
  // Cycles since last pin toggle
  // ------
  always_comb
  begin
    nxt_out_q = out_pin_out;
    nxt_gap = gap_ff + 32'h1;
    if (!reset_n || out_pin_oe_n || out_pin_out != out_q_ff)
      nxt_gap = 32'h0;
  end
  always_ff @(posedge clk)
  begin
    gap_ff <= nxt_gap;
    out_q_ff <= nxt_out_q;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_gap_max:
    assert property (!out_pin_oe_n |-> gap_ff <= OUT_BIT_CYC)
    else $error("pin missed a bit boundary");
  a_gap_min:
    assert property ($changed(out_pin_out) && !out_pin_oe_n &&
      !$past(out_pin_oe_n) |-> gap_ff >= OUT_BIT_CYC / 5 - 1)
    else $error("pin toggled too early");
  a_tx_start_high:
    assert property ($fell(out_pin_oe_n) |-> out_pin_out)
    else $error("answer did not start high");
  a_write_pulse:
    assert property (reg_write |=> !reg_write)
    else $error("write pulse too long");
  a_erase_pulse:
    assert property (erase_cmd |=> !erase_cmd)
    else $error("erase pulse too long");
  a_write_acks:
    assert property (reg_write |-> ##[0:2] !out_pin_oe_n)
    else $error("write without answer");
  a_burn_follow:
    assert property (burn_nv |-> $past(prog_level))
    else $error("burn without programming level");
  a_inactive_quiet:
    assert property (!active && !$past(active) |-> !reg_write)
    else $error("inactive sensor wrote");
  a_reset_idle:
    assert property (disable iff (1'b0)
      !reset_n |=> out_pin_oe_n && !burn_nv && active)
    else $error("reset state wrong");
endmodule

// ---- verification/prog_link_programmer.sv ----
module prog_link_programmer
(
  input wire logic clk,
  input wire logic out_pin_out,
  input wire logic out_pin_oe_n,
  output logic supply_level,
  output logic prog_level,
  output logic out_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 175;
  logic act_drive;
  assign out_pin_in = out_pin_oe_n ? act_drive : out_pin_out;
  initial
  begin
    supply_level = 1'h1;
    prog_level = 1'h0;
    act_drive = 1'h0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    supply_level <= ~supply_level;
  endtask
  task automatic send(input logic [23:0] w, input bit wr);
    step(1);
    step(P);
    for (int i = 23; i > (wr ? -1 : 14); i--)
    begin
      if (w[i])
      begin
        step(P * 65 / 100);
        step(P - P * 65 / 100);
      end
      else
        step(P);
    end
  endtask
  task automatic get(output logic [15:0] b, output int t, input int nb);
    logic lv;
    int k;
    b = 16'h0;
    t = 0;
    k = 0;
    while (out_pin_oe_n && k < 60)
    begin
      @(posedge clk);
      k++;
    end
    if (out_pin_oe_n)
    begin
      // Lets a refused frame time out first
      repeat (2 * P) @(posedge clk);
      return;
    end
    lv = out_pin_in;
    while (out_pin_in == lv && t < 500)
    begin
      @(posedge clk);
      t++;
    end
    for (int i = nb - 2; i >= 0; i--)
    begin
      lv = out_pin_in;
      repeat (t * 9 / 10) @(posedge clk);
      b[i] = out_pin_in != lv;
      repeat (t - t * 9 / 10) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic burn(input int n);
    // wait then hold
    // Sync of 175 cycles scales one ms to 100 cycles
    repeat (70) @(posedge clk);
    prog_level <= 1'h1;
    repeat (n) @(posedge clk);
    prog_level <= 1'h0;
  endtask
  task automatic select(input int n);
    @(posedge clk);
    act_drive <= 1'h1;
    repeat (n) @(posedge clk);
    act_drive <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
endmodule

// ---- verification/supply_modulated_prog_link_tb_top.sv ----
module supply_modulated_prog_link_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OUT = 300;
  logic clk;
  logic reset_n;
  logic supply_level, prog_level, out_pin_in, out_pin_out, out_pin_oe_n;
  logic [3:0] reg_sel;
  logic [13:0] reg_wdata, reg_rdata;
  logic reg_write, erase_cmd, lock_cmd, burn_nv, active;
  logic [15:0] ans;
  int per;
  int err_total = 0;
  int comparisons = 0;
  int n_wr = 0;
  int n_er = 0;
  int n_lk = 0;
  // Short counts keep the run small; activate ceiling left at default
  supply_modulated_prog_link #(.SYNC_MIN_CYC(170), .SYNC_MAX_CYC(180),
    .OUT_BIT_CYC(OUT), .ACT_MIN_CYC(10)) DUT (
    .clk(clk), .reset_n(reset_n), .supply_level(supply_level),
    .prog_level(prog_level), .out_pin_in(out_pin_in),
    .out_pin_out(out_pin_out), .out_pin_oe_n(out_pin_oe_n),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_rdata(reg_rdata), .erase_cmd(erase_cmd), .lock_cmd(lock_cmd),
    .burn_nv(burn_nv), .active(active));
  prog_link_programmer p (.clk(clk), .out_pin_out(out_pin_out),
    .out_pin_oe_n(out_pin_oe_n), .supply_level(supply_level),
    .prog_level(prog_level), .out_pin_in(out_pin_in));
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    n_wr += (reg_write === 1'h1);
    n_er += (erase_cmd === 1'h1);
    n_lk += (lock_cmd === 1'h1);
  end
  // ------
  // Shared helpers
  // ------
  function automatic logic [23:0] tg(logic [2:0] op, logic [3:0] s,
    logic [13:0] d);
    return {op, ^(~op), s, ^(~s), d, ~(^(~d))};
  endfunction
  task automatic chk(input string nm, input logic [23:0] s,
    input logic [23:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic xfer(input logic [23:0] w, input bit wr, input int nb);
    p.send(w, wr);
    p.get(ans, per, nb);
  endtask
  task automatic ack(input bit e);
    chk("ack", 24'(per >= OUT * 2 / 3 && per <= OUT * 4 / 3), 24'(e));
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_write();
    xfer(tg(3'h3, 4'h5, 14'h3fea), 1'b1, 1);
    ack(1);
    chk("wr_cnt", 24'(n_wr), 24'h1);
    chk("sel", 24'(reg_sel), 24'h5);
    chk("low_bits", 24'(reg_wdata[5:0]), 24'h2a);
  endtask
  task automatic t_refuse();
    logic [23:0] w;
    for (int i = 0; i < 3; i++)
    begin
      w = i == 2 ? tg(3'h3, 4'h4, 14'h1234) ^ 24'h1 :
        tg(3'h2, 4'h1, 14'h0) ^ (i == 0 ? 24'h100000 : 24'h008000);
      xfer(w, i == 2, 16);
      chk("refused", 24'(per), 24'h0);
    end
    chk("wr_cnt", 24'(n_wr), 24'h1);
  endtask
  task automatic t_read();
    logic [13:0] pl;
    @(posedge clk);
    reg_rdata <= 14'h3d55;
    pl = 14'h1550;
    xfer(tg(3'h2, 4'h1, 14'h0), 1'b0, 16);
    ack(1);
    chk("rd_w10", 24'(ans[14:0]), 24'({pl, ~(^(~pl))}));
    pl = 14'h2000;
    xfer(tg(3'h2, 4'h6, 14'h0), 1'b0, 16);
    chk("rd_w1", 24'(ans[14:0]), 24'({pl, ~(^(~pl))}));
  endtask
  task automatic t_cmds();
    xfer(tg(3'h5, 4'h0, 14'h0), 1'b0, 1);
    ack(1);
    xfer(tg(3'h7, 4'h0, 14'h0), 1'b0, 1);
    ack(1);
    xfer(tg(3'h6, 4'h0, 14'h0), 1'b0, 1);
    ack(0);
    chk("erase_lock", 24'({n_er[3:0], n_lk[3:0]}), 24'h11);
  endtask
  task automatic t_burn();
    xfer(tg(3'h4, 4'h0, 14'h0), 1'b0, 1);
    ack(1);
    fork
      p.burn(10000);
      begin
        repeat (500) @(posedge clk);
        chk("burn_on", 24'(burn_nv), 24'h1);
      end
    join
    repeat (3) @(posedge clk);
    chk("burn_off", 24'(burn_nv), 24'h0);
  endtask
  task automatic t_select();
    xfer(tg(3'h3, 4'hf, 14'h080f), 1'b1, 1);
    ack(1);
    chk("inactive", 24'(active), 24'h0);
    xfer(tg(3'h3, 4'h4, 14'h0001), 1'b1, 1);
    chk("ignored", 24'(per), 24'h0);
    p.select(15);
    chk("active", 24'(active), 24'h1);
    xfer(tg(3'h3, 4'h4, 14'h0001), 1'b1, 1);
    ack(1);
  endtask
  task automatic summarize();
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    reset_n = 1'h0;
    reg_rdata = 14'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    t_write();
    t_refuse();
    t_read();
    t_cmds();
    t_burn();
    t_select();
    summarize();
  end
  // Full run is near two thirds of this span
  initial
  begin
    repeat (90000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule
bind supply_modulated_prog_link prog_link_monitor #(
  .OUT_BIT_CYC(OUT_BIT_CYC)) mon (.clk(clk), .reset_n(reset_n),
  .prog_level(prog_level), .out_pin_out(out_pin_out),
  .out_pin_oe_n(out_pin_oe_n), .reg_write(reg_write),
  .erase_cmd(erase_cmd), .burn_nv(burn_nv), .active(active));
